// ==== logic/ucd_desc_store.sv ====
`timescale 1ns/1ps
`default_nettype none
module ucd_desc_store (
    // apb slave
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ucd_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // straps, from pins
    input  wire logic                      power_source_strap,
    input  wire logic                      remote_wakeup_strap,
    // descriptor requests from the control engine
    input  wire ucd_pkg::ucd_req_type      req,
    output ucd_pkg::ucd_rsp_type           rsp
);
    import ucd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // strap capture: three stage sync, latched once after reset release

    logic [2:0] pwr_sync_q;
    logic [2:0] rwk_sync_q;
    logic [1:0] settle_q;
    logic [1:0] settle_d;
    logic       strap_done_q;
    logic       self_pwr_q;
    logic       rwk_q;
    logic       straps_agree;
    logic       strap_take;

    assign straps_agree = (pwr_sync_q[1] == pwr_sync_q[2])
                        && (rwk_sync_q[1] == rwk_sync_q[2]);
    assign strap_take   = !strap_done_q
                        && (settle_q == 2'(STRAP_SETTLE))
                        && straps_agree;
    assign settle_d     = (settle_q == 2'(STRAP_SETTLE)) ? settle_q
                                                         : settle_q + 2'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_sync_q <= 3'h0;
            rwk_sync_q <= 3'h0;
            settle_q   <= 2'h0;
        end else begin
            pwr_sync_q <= {pwr_sync_q[1:0], power_source_strap};
            rwk_sync_q <= {rwk_sync_q[1:0], remote_wakeup_strap};
            settle_q   <= settle_d;
        end
    end

    // caught once only; later strap motion does not move the defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_done_q <= 1'b0;
            self_pwr_q   <= 1'b0;
            rwk_q        <= 1'b1;
        end else if (strap_take) begin
            strap_done_q <= 1'b1;
            self_pwr_q   <= pwr_sync_q[2];
            rwk_q        <= rwk_sync_q[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap-dependent defaults

    logic [7:0] def_attr;
    logic [7:0] def_power;

    // reads A0h for bus power with remote wakeup
    assign def_attr  = ATTR_BASE
                     | (8'(self_pwr_q) << ATTR_SELF_BIT)
                     | (8'(rwk_q) << ATTR_RWK_BIT);
    assign def_power = self_pwr_q ? DEF_PWR_SELF : DEF_PWR_BUS;

    ////////////////////////////////////////////////////////////////////////
    // apb register file

    logic            loaded_q;
    ucd_cfg_img_type cfg_img_q;
    ucd_ifc_img_type ifc_img_q;
    logic [7:0]      ival_hs_q;
    logic [7:0]      ival_fs_q;
    logic [15:0]     served_q;
    logic [31:0]     prdata_q;
    logic [31:0]     prdata_d;
    logic            pready_q;
    logic            pslverr_q;
    logic            pslverr_d;
    logic            access;
    logic            commit;
    logic            wr_commit;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    logic sel_ctrl;
    logic sel_cfg;
    logic sel_ifc;
    logic sel_poll;
    logic sel_stat;
    logic mapped;

    assign sel_ctrl  = hit(paddr, REG_CTRL);
    assign sel_cfg   = hit(paddr, REG_CFG);
    assign sel_ifc   = hit(paddr, REG_IFC);
    assign sel_poll  = hit(paddr, REG_POLL);
    assign sel_stat  = hit(paddr, REG_STATUS);
    assign mapped    = sel_ctrl | sel_cfg | sel_ifc | sel_poll | sel_stat;
    assign access    = psel && penable;
    // one wait state: pready rises on the second access cycle
    assign commit    = access && pready_q;
    assign wr_commit = commit && pwrite && mapped && !sel_stat;
    assign pslverr_d = !mapped || (pwrite && sel_stat);

    assign prdata_d =
        sel_ctrl ? {31'h0, loaded_q} :
        sel_cfg  ? cfg_img_q :
        sel_ifc  ? ifc_img_q :
        sel_poll ? {16'h0, ival_fs_q, ival_hs_q} :
        sel_stat ? {served_q, 4'h0, 1'(strap_done_q), 1'(req.speed_hs),
                    1'(rwk_q), 1'(self_pwr_q), def_attr} :
                   32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= access && !pready_q;
            pslverr_q <= access && !pready_q && pslverr_d;
            prdata_q  <= (access && !pready_q && !pwrite) ? prdata_d
                                                          : 32'h0;
        end
    end

    // image fields reset to plain defaults; strap defaults apply until load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loaded_q  <= 1'b0;
            cfg_img_q <= {DEF_ICFG, DEF_ATTR, DEF_PWR_BUS, CFG_TYPE};
            ifc_img_q <= {DEF_CLASS, DEF_SUBCLASS, DEF_PROTOCOL, DEF_IIF};
            ival_hs_q <= DEF_IVAL_HS;
            ival_fs_q <= DEF_IVAL_FS;
        end else if (wr_commit) begin
            if (sel_ctrl)
                loaded_q <= pwdata[0];
            if (sel_cfg)
                cfg_img_q <= pwdata;
            if (sel_ifc)
                ifc_img_q <= pwdata;
            if (sel_poll) begin
                ival_hs_q <= pwdata[7:0];
                ival_fs_q <= pwdata[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // effective field values

    logic [7:0] eff_icfg;
    logic [7:0] eff_attr;
    logic [7:0] eff_power;
    logic [7:0] eff_class;
    logic [7:0] eff_sub;
    logic [7:0] eff_proto;
    logic [7:0] eff_iif;
    logic [7:0] eff_ival;
    logic [15:0] bulk_mps;

    assign eff_icfg  = loaded_q ? cfg_img_q.icfg : DEF_ICFG;
    assign eff_attr  = loaded_q ? cfg_img_q.attr : def_attr;
    assign eff_power = loaded_q ? cfg_img_q.max_power : def_power;
    assign eff_class = loaded_q ? ifc_img_q.iface_class : DEF_CLASS;
    assign eff_sub   = loaded_q ? ifc_img_q.subclass : DEF_SUBCLASS;
    assign eff_proto = loaded_q ? ifc_img_q.protocol : DEF_PROTOCOL;
    assign eff_iif   = loaded_q ? ifc_img_q.iif : DEF_IIF;
    // interval table always live; defaults sit in the reset values
    assign eff_ival  = req.speed_hs ? ival_hs_q : ival_fs_q;
    assign bulk_mps  = req.speed_hs ? MPS_HS : MPS_FS;

    ////////////////////////////////////////////////////////////////////////
    // descriptor bundle: config, interface, ep1, ep2, ep3, in wire order

    logic [BUNDLE_BYTES*8-1:0] bundle;

    // standard-fixed fields are hardwired, so an image that disagrees
    // cannot corrupt them
    assign bundle = {
        CFG_LEN,
        CFG_TYPE,
        CFG_TOTAL[7:0], CFG_TOTAL[15:8],
        CFG_NUM_IF, CFG_VALUE,
        eff_icfg, eff_attr, eff_power,
        IF_LEN, IF_TYPE, IF_NUMBER, IF_ALT, IF_NUM_EP,
        eff_class, eff_sub, eff_proto, eff_iif,
        EP_LEN, EP_TYPE, EP1_ADDR, EP_BULK,
        bulk_mps[7:0], bulk_mps[15:8], BULK_IVAL,
        EP_LEN, EP_TYPE, EP2_ADDR, EP_BULK,
        bulk_mps[7:0], bulk_mps[15:8], BULK_IVAL,
        EP_LEN, EP_TYPE, EP3_ADDR, EP_INTR,
        MPS_INTR[7:0], MPS_INTR[15:8], eff_ival
    };

    ////////////////////////////////////////////////////////////////////////
    // request service: one byte per request, answered next edge

    logic       in_range;
    logic       is_last;
    logic [7:0] byte_sel;
    logic [5:0] rev_idx;
    ucd_rsp_type rsp_q;
    ucd_rsp_type rsp_d;

    assign in_range = (req.offset < 6'(BUNDLE_BYTES));
    assign is_last  = (req.offset == 6'(BUNDLE_BYTES - 1));
    assign rev_idx  = 6'(BUNDLE_BYTES - 1) - req.offset;
    // out of range reads as zero rather than aliasing
    assign byte_sel = in_range ? bundle[rev_idx*8 +: 8] : 8'h00;
    assign rsp_d    = '{valid:  req.valid,
                        data:   req.valid ? byte_sel : 8'h00,
                        last:   req.valid && is_last,
                        beyond: req.valid && !in_range};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_q    <= '0;
            served_q <= 16'h0;
        end else begin
            rsp_q <= rsp_d;
            if (req.valid && is_last)
                served_q <= served_q + 16'h1;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign rsp     = rsp_q;

endmodule
`default_nettype wire

// ==== logic/ucd_pkg.sv ====
// How it works
// - configuration descriptor is nine bytes, same defaults at both speeds
// - configuration type byte always forced to two, image value ignored
// - total length reported as thirty-nine bytes for the whole bundle
// - one interface, configuration selection value one
// - configuration string index from image, zero when nothing loaded
// - attributes byte from image; default bus powered with remote wakeup
// - default attributes follow power and wakeup straps caught at reset
// - max power byte from image; default 01h self, FAh bus powered
// - interface descriptor nine bytes, type four, number zero, three endpoints
// - class, subclass, protocol, string index from image; FFh 00h FFh 00h
// - each endpoint descriptor seven bytes, type five, hardwired except the endpoint 3 interval
// - endpoint 1 bulk in, address 81h, attributes 02h, fixed
// - bulk in max packet 64 bytes full speed, 512 high speed
// - endpoint 2 bulk out, address 02h, bulk attributes, fixed
// - bulk endpoints report polling interval zero
// - endpoint 3 interrupt, 83h, attributes 03h, max packet 10h
// - separate interrupt intervals; defaults 04h high, 01h full speed
// - configuration defaults identical at full and high speed
package ucd_pkg;

    // descriptor constants
    localparam logic [7:0]  CFG_LEN      = 8'h09;
    localparam logic [7:0]  CFG_TYPE     = 8'h02;
    localparam logic [15:0] CFG_TOTAL    = 16'h0027;
    localparam logic [7:0]  CFG_NUM_IF   = 8'h01;
    localparam logic [7:0]  CFG_VALUE    = 8'h01;
    localparam logic [7:0]  IF_LEN       = 8'h09;
    localparam logic [7:0]  IF_TYPE      = 8'h04;
    localparam logic [7:0]  IF_NUMBER    = 8'h00;
    localparam logic [7:0]  IF_ALT       = 8'h00;
    localparam logic [7:0]  IF_NUM_EP    = 8'h03;
    localparam logic [7:0]  EP_LEN       = 8'h07;
    localparam logic [7:0]  EP_TYPE      = 8'h05;
    localparam logic [7:0]  EP1_ADDR     = 8'h81;
    localparam logic [7:0]  EP2_ADDR     = 8'h02;
    localparam logic [7:0]  EP3_ADDR     = 8'h83;
    localparam logic [7:0]  EP_BULK      = 8'h02;
    localparam logic [7:0]  EP_INTR      = 8'h03;
    localparam logic [15:0] MPS_FS       = 16'h0040;
    localparam logic [15:0] MPS_HS       = 16'h0200;
    localparam logic [15:0] MPS_INTR     = 16'h0010;
    localparam logic [7:0]  BULK_IVAL    = 8'h00;
    localparam int          BUNDLE_BYTES = 39;

    // defaults of image-loaded fields
    localparam logic [7:0] DEF_ICFG      = 8'h00;
    localparam logic [7:0] DEF_ATTR      = 8'hA0;
    localparam logic [7:0] ATTR_BASE     = 8'h80;
    localparam int         ATTR_SELF_BIT = 6;
    localparam int         ATTR_RWK_BIT  = 5;
    localparam logic [7:0] DEF_PWR_SELF  = 8'h01;
    localparam logic [7:0] DEF_PWR_BUS   = 8'hFA;
    localparam logic [7:0] DEF_CLASS     = 8'hFF;
    localparam logic [7:0] DEF_SUBCLASS  = 8'h00;
    localparam logic [7:0] DEF_PROTOCOL  = 8'hFF;
    localparam logic [7:0] DEF_IIF       = 8'h00;
    localparam logic [7:0] DEF_IVAL_HS   = 8'h04;
    localparam logic [7:0] DEF_IVAL_FS   = 8'h01;

    // register map, byte addresses
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_CFG       = 8'h04;
    localparam logic [7:0] REG_IFC       = 8'h08;
    localparam logic [7:0] REG_POLL      = 8'h0C;
    localparam logic [7:0] REG_STATUS    = 8'h10;
    localparam int         ADDR_W        = 8;
    localparam int         STRAP_SETTLE  = 3;

    typedef struct packed {
        logic [7:0] icfg;
        logic [7:0] attr;
        logic [7:0] max_power;
        logic [7:0] type_img;
    } ucd_cfg_img_type;

    typedef struct packed {
        logic [7:0] iface_class;
        logic [7:0] subclass;
        logic [7:0] protocol;
        logic [7:0] iif;
    } ucd_ifc_img_type;

    typedef struct packed {
        logic       valid;
        logic [5:0] offset;
        logic       speed_hs;
    } ucd_req_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
        logic       beyond;
    } ucd_rsp_type;

endpackage

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ucd_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic              pwr_s, wak_s, er;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    ucd_req_type       req;
    ucd_rsp_type       rsp;
    int                fail_count = 0;
    int                checks_done = 0;
    ucd_desc_store dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_source_strap(pwr_s),
        .remote_wakeup_strap(wak_s), .req(req), .rsp(rsp)
    );
    ucd_host_model host_u (.pclk(pclk), .req(req), .rsp(rsp));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // look mid-cycle so the answer is settled, then close on the edge
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            final_report();
        end
        rd = prdata;
        er = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // whole bundle at one speed against the values the rules give
    task automatic bundle(input logic hs, input logic [31:0] c, f, p);
        logic [0:38][7:0] v;
        logic [15:0]      m;
        m = hs ? 16'h0200 : 16'h0040;
        v = {8'h09, 8'h02, 8'h27, 8'h00, 8'h01, 8'h01, c[31:24], c[23:16],
             c[15:8], 8'h09, 8'h04, 8'h00, 8'h00, 8'h03, f[31:24], f[23:16],
             f[15:8], f[7:0], 8'h07, 8'h05, 8'h81, 8'h02, m[7:0], m[15:8],
             8'h00, 8'h07, 8'h05, 8'h02, 8'h02, m[7:0], m[15:8], 8'h00,
             8'h07, 8'h05, 8'h83, 8'h03, 8'h10, 8'h00, hs ? p[7:0] : p[15:8]};
        host_u.fetch(hs);
        for (int i = 0; i < 39; i++)
            check($sformatf("byte %0d", i), 32'(host_u.got[i]),
                  32'({1'b1, v[i], i == 38, 1'b0}));
        check("beyond", 32'(host_u.got[39]), 32'h401);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pwr_s = 1'b0;
        wak_s = 1'b1;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, REG_CFG, 32'h0);
        check("cfg reset", rd, 32'h00A0FA02);
        apb(1'b0, REG_IFC, 32'h0);
        check("ifc reset", rd, 32'hFF00FF00);
        apb(1'b0, REG_POLL, 32'h0);
        check("poll reset", rd, 32'h00000104);
        apb(1'b0, REG_STATUS, 32'h0);
        check("straps", 32'({rd[11], rd[9:0]}), 32'h6A0);
        bundle(1'b1, 32'h00A0FA00, 32'hFF00FF00, 32'h0104);
        bundle(1'b0, 32'h00A0FA00, 32'hFF00FF00, 32'h0104);
        // refused accesses
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped", {er, rd[30:0]}, 32'h80000000);
        apb(1'b1, REG_STATUS, 32'hFFFFFFFF);
        check("status write", 32'(er), 32'h1);
        // image with a junk type byte; fixed fields still hold
        apb(1'b1, REG_CFG, 32'h07C03255);
        apb(1'b1, REG_IFC, 32'h0A0B0C0D);
        apb(1'b1, REG_POLL, 32'h00000208);
        apb(1'b1, REG_CTRL, 32'h00000001);
        bundle(1'b1, 32'h07C03200, 32'h0A0B0C0D, 32'h0208);
        bundle(1'b0, 32'h07C03200, 32'h0A0B0C0D, 32'h0208);
        // self powered, no wakeup: second reset mid-run
        @(posedge pclk);
        pwr_s <= 1'b1;
        wak_s <= 1'b0;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        bundle(1'b0, 32'h00C00100, 32'hFF00FF00, 32'h0104);
        final_report();
    end
endmodule
`default_nettype wire

// ==== tb/ucd_desc_store_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module ucd_desc_store_sva (
    // clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // apb answer
    input wire logic                 pready,
    // descriptor path
    input wire ucd_pkg::ucd_req_type req,
    input wire ucd_pkg::ucd_rsp_type rsp
);
    import ucd_pkg::*;
    wire logic       rq_v  = req.valid;
    wire logic [5:0] rq_o  = req.offset;
    wire logic       rq_hs = req.speed_hs;
    wire logic [7:0] rs_d  = rsp.data;
    // expected endpoint address, judged against the previous request
    wire logic [7:0] ep_a  = (rq_o == 6'd20) ? 8'h81 :
                             (rq_o == 6'd27) ? 8'h02 : 8'h83;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    property p_next; rq_v |=> rsp.valid; endproperty
    a_next: assert property (p_next)
        else $error("no response one cycle after request");
    property p_len; rq_v && rq_o == 6'd0 |=> rs_d == 8'h09; endproperty
    a_len: assert property (p_len)
        else $error("config length byte wrong");
    property p_type; rq_v && rq_o == 6'd1 |=> rs_d == 8'h02; endproperty
    a_type: assert property (p_type)
        else $error("config type byte not forced");
    property p_total; rq_v && rq_o == 6'd2 |=> rs_d == 8'h27; endproperty
    a_total: assert property (p_total)
        else $error("total length low byte wrong");
    property p_ep_len;
        rq_v && rq_o inside {6'd18, 6'd25, 6'd32} |=> rs_d == 8'h07;
    endproperty
    a_ep_len: assert property (p_ep_len)
        else $error("endpoint length byte wrong");
    property p_ep_addr;
        rq_v && rq_o inside {6'd20, 6'd27, 6'd34} |=> rs_d == $past(ep_a);
    endproperty
    a_ep_addr: assert property (p_ep_addr)
        else $error("endpoint address byte wrong");
    property p_mps;
        rq_v && rq_o inside {6'd23, 6'd30} |=>
            rs_d == {6'h00, $past(rq_hs), 1'b0};
    endproperty
    a_mps: assert property (p_mps)
        else $error("bulk packet size high byte wrong");
    property p_beyond;
        rq_v && rq_o > 6'd38 |=> rsp.beyond && rs_d == 8'h00;
    endproperty
    a_beyond: assert property (p_beyond)
        else $error("offset past bundle not refused");
    property p_last; rq_v |=> rsp.last == ($past(rq_o) == 6'd38); endproperty
    a_last: assert property (p_last)
        else $error("last flag misplaced");
    property p_ready; pready |=> !pready; endproperty
    a_ready: assert property (p_ready)
        else $error("apb ready longer than one cycle");
endmodule
bind ucd_desc_store ucd_desc_store_sva chk_u (
    .pclk(pclk),
    .presetn(presetn),
    .pready(pready),
    .req(req),
    .rsp(rsp)
);
`default_nettype wire

// ==== tb/ucd_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ucd_host_model (
    // clock
    input  wire logic                 pclk,
    // descriptor path
    output var ucd_pkg::ucd_req_type  req,
    input  wire ucd_pkg::ucd_rsp_type rsp
);
    import ucd_pkg::*;
    ucd_rsp_type got [0:39];
    initial req = '0;
    // offsets 0..39 back to back, one past the bundle to see the refusal
    task automatic fetch(input logic hs);
        for (int i = 0; i <= 40; i++) begin
            @(posedge pclk);
            if (i < 40) req <= '{1'b1, 6'(i), hs};
            // released: offset and speed no longer hold the last request
            else req <= '{1'b0, ~req.offset, ~hs};
            @(negedge pclk);
            if (i > 0) got[i-1] = rsp;
        end
    endtask
endmodule
`default_nettype wire
